// ---- verilog/pom_pkg.sv ----
// package: register map, field layout and codes of the pin 2 output mux
package pom_pkg;

  // ---------------------------------------------------------------
  // register map (indices, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] POM_CTRL_IDX  = 8'h12;
  localparam logic [7:0] POM_CTRL_ADDR = {POM_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] POM_STAT_IDX  = 8'h20;
  localparam logic [7:0] POM_STAT_ADDR = {POM_STAT_IDX[5:0], 2'b00};
  localparam logic [7:0] POM_CTRL_RST  = 8'h00;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int unsigned POM_SEL_HI = 7;
  localparam int unsigned POM_SEL_LO = 5;
  localparam int unsigned POM_SRC_HI = 4;
  localparam int unsigned POM_SRC_LO = 2;
  localparam int unsigned POM_VAL_BIT = 1;
  localparam int unsigned POM_EN_BIT = 0;

  // status field positions
  localparam int unsigned POM_ST_PIN_BIT = 0;
  localparam int unsigned POM_ST_OE_BIT  = 1;
  localparam int unsigned POM_ST_RSV_BIT = 2;

  // ---------------------------------------------------------------
  // source and select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] POM_SRC_RX3   = 3'h3;
  localparam logic [2:0] POM_SRC_DEV   = 3'h4;
  localparam logic [2:0] POM_SRC_TX    = 3'h6;
  localparam logic [2:0] POM_SEL_RGP3  = 3'h3;
  localparam logic [2:0] POM_SEL_LOCK  = 3'h4;
  localparam logic [2:0] POM_SEL_PASS  = 3'h5;
  localparam logic [2:0] POM_SEL_FV    = 3'h6;
  localparam logic [2:0] POM_SEL_LV    = 3'h7;
  localparam logic [2:0] POM_DSEL_VAL  = 3'h0;
  localparam logic [2:0] POM_DSEL_LOCK = 3'h1;
  localparam logic [2:0] POM_DSEL_PASA = 3'h2;
  localparam logic [2:0] POM_DSEL_PASB = 3'h3;
  localparam logic [2:0] POM_DSEL_FS   = 3'h4;
  localparam logic [2:0] POM_TSEL_AND  = 3'h0;
  localparam logic [2:0] POM_TSEL_OR   = 3'h1;
  localparam logic [2:0] POM_TSEL_FV   = 3'h2;
  localparam logic [2:0] POM_TSEL_LV   = 3'h3;
  localparam logic [2:0] POM_TSEL_SYN  = 3'h4;
  localparam logic [2:0] POM_TSEL_IRQ  = 3'h5;

  // bus responses
  localparam logic [1:0] POM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] POM_RESP_SLVERR = 2'h2;

  function automatic logic pom_is_mapped(input logic [7:0] addr);
    return (addr == POM_CTRL_ADDR) || (addr == POM_STAT_ADDR);
  endfunction : pom_is_mapped

  // with nothing enabled the AND reads low, not vacuously high
  function automatic logic pom_and_en(input logic [3:0] v,
                                      input logic [3:0] en);
    return (&(v | ~en)) & (|en);
  endfunction : pom_and_en

  function automatic logic pom_or_en(input logic [3:0] v,
                                     input logic [3:0] en);
    return |(v & en);
  endfunction : pom_or_en

endpackage : pom_pkg

// ---- verilog/pom_axil_slave.sv ----
// file: axi4-lite slave front end for the pin 2 output mux registers
`timescale 1ns/1ps
module pom_axil_slave
  import pom_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        awvalid_in,
  output wire logic        awready_out,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        wvalid_in,
  output wire logic        wready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  output wire logic        bvalid_out,
  input  wire logic        bready_in,
  output wire logic [1:0]  bresp_out,
  input  wire logic        arvalid_in,
  output wire logic        arready_out,
  input  wire logic [7:0]  araddr_in,
  output wire logic        rvalid_out,
  input  wire logic        rready_in,
  output wire logic [31:0] rdata_out,
  output wire logic [1:0]  rresp_out,
  input  wire logic [31:0] rd_word_in,
  output logic             wr_en_out,
  output logic [7:0]       wr_addr_out,
  output logic [31:0]      wr_data_out,
  output logic [3:0]       wr_strb_out
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pom_axil_s;

  pom_axil_s s_q;
  pom_axil_s s_d;

  always_comb begin
    logic aw_hs;
    logic w_hs;
    aw_hs = awvalid_in & s_q.awready;
    w_hs  = wvalid_in & s_q.wready;
    s_d   = s_q;
    if (aw_hs) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = awaddr_in;
    end
    if (w_hs) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = wdata_in;
      s_d.w_strb = wstrb_in;
    end
    if (s_q.bvalid && bready_in) begin
      s_d.bvalid = 1'b0;
    end
    // write commits in the cycle both halves are held or arriving
    wr_en_out   = s_d.aw_got & s_d.w_got & ~s_q.bvalid;
    wr_addr_out = s_d.aw_addr;
    wr_data_out = s_d.w_data;
    wr_strb_out = s_d.w_strb;
    if (wr_en_out) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = pom_is_mapped(s_d.aw_addr) ? POM_RESP_OKAY
                                              : POM_RESP_SLVERR;
    end
    // one write outstanding: no new halves until the response drains
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_got & ~s_d.bvalid;
    if (s_q.rvalid && rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid_in && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word_in;
      s_d.rresp  = pom_is_mapped(araddr_in) ? POM_RESP_OKAY
                                            : POM_RESP_SLVERR;
    end
    s_d.arready = ~s_d.rvalid;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready_out = s_q.awready;
  assign wready_out  = s_q.wready;
  assign bvalid_out  = s_q.bvalid;
  assign bresp_out   = s_q.bresp;
  assign arready_out = s_q.arready;
  assign rvalid_out  = s_q.rvalid;
  assign rdata_out   = s_q.rdata;
  assign rresp_out   = s_q.rresp;

endmodule : pom_axil_slave

// ---- verilog/pom_signal_mux.sv ----
// file: source and select decode for the pin 2 output level
`timescale 1ns/1ps
module pom_signal_mux
  import pom_pkg::*;
(
  input  wire logic [2:0]  src_in,
  input  wire logic [2:0]  sel_in,
  input  wire logic        static_value_in,
  input  wire logic [15:0] rx_remote_gpio_in,
  input  wire logic [3:0]  rx_lock_in,
  input  wire logic [3:0]  rx_pass_in,
  input  wire logic [3:0]  rx_frame_valid_in,
  input  wire logic [3:0]  rx_line_valid_in,
  input  wire logic [3:0]  rx_port_enable_in,
  input  wire logic [3:0]  tx_port_select_in,
  input  wire logic        frame_sync_pulse_in,
  input  wire logic        tx_frame_active_in,
  input  wire logic        tx_line_active_in,
  input  wire logic        tx_synced_in,
  input  wire logic        tx_irq_in,
  output logic             level_out,
  output logic             reserved_out
);

  always_comb begin
    logic [1:0] port;
    port         = src_in[1:0];
    level_out    = 1'b0;
    reserved_out = 1'b0;
    if (src_in <= POM_SRC_RX3) begin
      unique case (sel_in) // RL1
        POM_SEL_LOCK: level_out = rx_lock_in[port]; // RL4
        POM_SEL_PASS: level_out = rx_pass_in[port]; // RL4
        POM_SEL_FV:   level_out = rx_frame_valid_in[port]; // RL4
        POM_SEL_LV:   level_out = rx_line_valid_in[port]; // RL4
        default:      level_out =
                        rx_remote_gpio_in[{port, sel_in[1:0]}]; // RL3
      endcase
    end else if (src_in == POM_SRC_DEV) begin // RL2
      unique case (sel_in)
        POM_DSEL_VAL:  level_out = static_value_in; // RL5
        POM_DSEL_LOCK: level_out = pom_or_en(rx_lock_in,
                                             rx_port_enable_in); // RL6
        POM_DSEL_PASA,
        POM_DSEL_PASB: level_out = pom_and_en(rx_pass_in,
                                              rx_port_enable_in); // RL7
        POM_DSEL_FS:   level_out = frame_sync_pulse_in; // RL8
        default:       reserved_out = 1'b1; // RL14
      endcase
    end else if (src_in == POM_SRC_TX) begin // RL2
      unique case (sel_in)
        POM_TSEL_AND: level_out = pom_and_en(rx_pass_in,
                                             tx_port_select_in); // RL9
        POM_TSEL_OR:  level_out = pom_or_en(rx_pass_in,
                                            tx_port_select_in); // RL9
        POM_TSEL_FV:  level_out = tx_frame_active_in; // RL10
        POM_TSEL_LV:  level_out = tx_line_active_in; // RL10
        POM_TSEL_SYN: level_out = tx_synced_in; // RL11
        POM_TSEL_IRQ: level_out = tx_irq_in; // RL11
        default:      reserved_out = 1'b1; // RL14
      endcase
    end else begin
      reserved_out = 1'b1; // RL14
    end
  end

endmodule : pom_signal_mux

// ---- verilog/pom_pin2_output_mux.sv ----
// file: top of the pin 2 output mux with its control register
// ---------------------------------------------------------------
// Notes on behaviour
// RL1 - source codes 000..011 route receive ports 0..3 to the pin
// RL2 - source 100 is device status, 110 the transmit port; 101, 111 reserved
// RL3 - receive source, select 000..011: that port's remote inputs 0..3
// RL4 - receive source, select 100..111: lock, pass, frame valid, line valid
// RL5 - status source, select 000: the static value bit
// RL6 - status source, select 001: OR of lock over enabled receive ports
// RL7 - status source, select 011 (and 010): AND of pass over enabled ports
// RL8 - status source, select 100: frame sync; 101..111 reserved
// RL9 - transmit source, 000: AND, 001: OR of pass over selected ports
// RL10 - transmit source, 010: frame being sent, 011: line being sent
// RL11 - transmit source, 100: ports synchronised, 101: transmit interrupt
// RL12 - bit 0 enables the pin driver; resets to 0, pin undriven
// RL13 - static value bit drives the pin only when selected and enabled
// RL14 - reserved or undocumented codes drive the pin low while enabled
// ---------------------------------------------------------------
`timescale 1ns/1ps
module pom_pin2_output_mux
  import pom_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        s_axi_awvalid_in,
  output wire logic        s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output wire logic        s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output wire logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output wire logic [1:0]  s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output wire logic        s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  output wire logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output wire logic [31:0] s_axi_rdata_out,
  output wire logic [1:0]  s_axi_rresp_out,
  input  wire logic [15:0] rx_remote_gpio_in,
  input  wire logic [3:0]  rx_lock_in,
  input  wire logic [3:0]  rx_pass_in,
  input  wire logic [3:0]  rx_frame_valid_in,
  input  wire logic [3:0]  rx_line_valid_in,
  input  wire logic [3:0]  rx_port_enable_in,
  input  wire logic [3:0]  tx_port_select_in,
  input  wire logic        frame_sync_pulse_in,
  input  wire logic        tx_frame_active_in,
  input  wire logic        tx_line_active_in,
  input  wire logic        tx_synced_in,
  input  wire logic        tx_irq_in,
  output wire logic        pin2_data_out,
  output wire logic        pin2_oe_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic       pin;
    logic       oe;
    logic       rsv;
  } pom_top_s;

  pom_top_s    s_q;
  pom_top_s    s_d;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] rd_word;
  logic        level;
  logic        reserved;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  pom_axil_slave u_bus (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .awvalid_in  (s_axi_awvalid_in),
    .awready_out (s_axi_awready_out),
    .awaddr_in   (s_axi_awaddr_in),
    .wvalid_in   (s_axi_wvalid_in),
    .wready_out  (s_axi_wready_out),
    .wdata_in    (s_axi_wdata_in),
    .wstrb_in    (s_axi_wstrb_in),
    .bvalid_out  (s_axi_bvalid_out),
    .bready_in   (s_axi_bready_in),
    .bresp_out   (s_axi_bresp_out),
    .arvalid_in  (s_axi_arvalid_in),
    .arready_out (s_axi_arready_out),
    .araddr_in   (s_axi_araddr_in),
    .rvalid_out  (s_axi_rvalid_out),
    .rready_in   (s_axi_rready_in),
    .rdata_out   (s_axi_rdata_out),
    .rresp_out   (s_axi_rresp_out),
    .rd_word_in  (rd_word),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb)
  );

  // ---------------------------------------------------------------
  // signal selection
  // ---------------------------------------------------------------
  pom_signal_mux u_mux (
    .src_in              (s_q.ctrl[POM_SRC_HI:POM_SRC_LO]),
    .sel_in              (s_q.ctrl[POM_SEL_HI:POM_SEL_LO]),
    .static_value_in     (s_q.ctrl[POM_VAL_BIT]),
    .rx_remote_gpio_in   (rx_remote_gpio_in),
    .rx_lock_in          (rx_lock_in),
    .rx_pass_in          (rx_pass_in),
    .rx_frame_valid_in   (rx_frame_valid_in),
    .rx_line_valid_in    (rx_line_valid_in),
    .rx_port_enable_in   (rx_port_enable_in),
    .tx_port_select_in   (tx_port_select_in),
    .frame_sync_pulse_in (frame_sync_pulse_in),
    .tx_frame_active_in  (tx_frame_active_in),
    .tx_line_active_in   (tx_line_active_in),
    .tx_synced_in        (tx_synced_in),
    .tx_irq_in           (tx_irq_in),
    .level_out           (level),
    .reserved_out        (reserved)
  );

  // ---------------------------------------------------------------
  // read data, sampled by the slave on the address handshake
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr_in == POM_CTRL_ADDR) begin
      rd_word[7:0] = s_q.ctrl;
    end else if (s_axi_araddr_in == POM_STAT_ADDR) begin
      rd_word[POM_ST_PIN_BIT] = s_q.pin;
      rd_word[POM_ST_OE_BIT]  = s_q.oe;
      rd_word[POM_ST_RSV_BIT] = s_q.rsv;
    end
  end

  // ---------------------------------------------------------------
  // control register and pin flops
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // status register is read only; writes to it are dropped
    if (wr_en && wr_addr == POM_CTRL_ADDR && wr_strb[0]) begin
      s_d.ctrl = wr_data[7:0];
    end
    s_d.oe  = s_q.ctrl[POM_EN_BIT]; // RL12
    s_d.rsv = reserved;
    // the pin is registered so the driver never glitches on a decode
    s_d.pin = s_q.ctrl[POM_EN_BIT] & level & ~reserved; // RL13 RL14
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q      <= '0;
      s_q.ctrl <= POM_CTRL_RST; // RL12 RL13
    end else begin
      s_q <= s_d;
    end
  end

  assign pin2_data_out = s_q.pin;
  assign pin2_oe_out   = s_q.oe;

endmodule : pom_pin2_output_mux

// ---- bench/pom_pin2_output_mux_asserts.sv ----
// checker: bus handshake and pin driver relations of the pin 2 output mux
`timescale 1ns/1ps
module pom_pin2_output_mux_chk (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        pin2_data_out,
  input wire logic        pin2_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  undriven_low_a: assert property (!pin2_oe_out |-> !pin2_data_out)
    else $error("pin data high while undriven");
  // reset itself is the cause here, so this one is never disabled
  reset_off_a: assert property (disable iff (1'h0)
    rst_in |=> !pin2_oe_out && !pin2_data_out)
    else $error("pin driven after reset");
  oe_write_only_a: assert property (
    $changed(pin2_oe_out) |-> $past(s_axi_bvalid_out))
    else $error("driver enable moved without a register write");
  b_after_both_a: assert property (s_axi_awvalid_in && s_axi_awready_out
    && s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out)
    else $error("write response late");
  no_aw_pend_a: assert property (s_axi_bvalid_out |->
    !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  r_after_ar_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out)
    else $error("read response late");
  no_ar_pend_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while data pending");
  r_upper_zero_a: assert property (s_axi_rvalid_out |->
    s_axi_rdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");

  cover property (s_axi_bvalid_out && s_axi_bready_in);
  cover property (s_axi_rvalid_out && s_axi_rready_in);
  cover property ($rose(pin2_oe_out));
endmodule : pom_pin2_output_mux_chk

bind pom_pin2_output_mux
  pom_pin2_output_mux_chk i_pom_pin2_output_mux_chk (.*);

// ---- bench/pom_pin_reader.sv ----
// partner: external circuit reading pin 2 through a board pull-down
`timescale 1ns/1ps
module pom_pin_reader (
  input  wire logic pin2_data_in,
  input  wire logic pin2_oe_in,
  output wire logic pin_level_out
);
  // an undriven line settles low through the pull-down, never holds a value
  assign pin_level_out = pin2_oe_in ? pin2_data_in : 1'h0;
endmodule : pom_pin_reader

// ---- bench/pom_pin2_output_mux_tb_top.sv ----
// testbench: register access and every source/select code of the pin mux
`timescale 1ns/1ps
module pom_pin2_output_mux_tb_top;
  import pom_pkg::*;
  logic        ref_clk_in = '0, rst_in = 1'h1;
  logic        s_axi_awvalid_in = '0, s_axi_wvalid_in = '0;
  logic        s_axi_bready_in = '0, s_axi_arvalid_in = '0;
  logic        s_axi_rready_in = '0;
  logic [7:0]  s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0;
  logic [3:0]  s_axi_wstrb_in = '0;
  wire logic   s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire logic   s_axi_arready_out, s_axi_rvalid_out;
  wire logic   pin2_data_out, pin2_oe_out, pin_level;
  wire logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  wire logic [31:0] s_axi_rdata_out;
  logic [15:0] rx_remote_gpio_in = '0;
  logic [3:0]  rx_lock_in = '0, rx_pass_in = '0, rx_frame_valid_in = '0;
  logic [3:0]  rx_line_valid_in = '0, rx_port_enable_in = '0;
  logic [3:0]  tx_port_select_in = '0;
  logic        frame_sync_pulse_in = '0, tx_frame_active_in = '0;
  logic        tx_line_active_in = '0, tx_synced_in = '0, tx_irq_in = '0;
  int          mismatches = 0, checks_done = 0;

  pom_pin2_output_mux i_pom_pin2_output_mux (.*);
  pom_pin_reader i_pom_pin_reader (.pin2_data_in(pin2_data_out),
    .pin2_oe_in(pin2_oe_out), .pin_level_out(pin_level));

  always #12.5 ref_clk_in = ~ref_clk_in;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // readies are sampled before this edge's updates land
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
    // a fresh edge keeps the last call's releases apart from this request
    @(posedge ref_clk_in);
    r = 2'h3;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_bvalid_out) begin
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
        return;
      end
    end
    mismatches++;
    give_verdict();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge ref_clk_in);
    d = '0;
    r = 2'h3;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      if (s_axi_rvalid_out) begin
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
        return;
      end
    end
    mismatches++;
    give_verdict();
  endtask : axr

  // pattern and its inverse flip every AND/OR result at least once
  task automatic set_in(input logic i);
    rx_remote_gpio_in <= 16'h5A3C ^ {16{i}};
    rx_lock_in <= 4'h2 ^ {4{i}};
    rx_pass_in <= 4'hD ^ {4{i}};
    rx_frame_valid_in <= 4'h9 ^ {4{i}};
    rx_line_valid_in <= 4'h6 ^ {4{i}};
    rx_port_enable_in <= 4'hD;
    tx_port_select_in <= 4'h5;
    frame_sync_pulse_in <= i;
    tx_frame_active_in <= ~i;
    tx_line_active_in <= i;
    tx_synced_in <= ~i;
    tx_irq_in <= i;
  endtask : set_in

  function automatic logic exp_pin(input logic [2:0] c, input logic [2:0] l,
                                   input logic v);
    logic [1:0] p;
    p = c[1:0];
    case (c)
      3'h0, 3'h1, 3'h2, 3'h3:
        case (l)
          3'h4: return rx_lock_in[p];
          3'h5: return rx_pass_in[p];
          3'h6: return rx_frame_valid_in[p];
          3'h7: return rx_line_valid_in[p];
          default: return rx_remote_gpio_in[{p, l[1:0]}];
        endcase
      3'h4:
        case (l)
          3'h0: return v;
          3'h1: return |(rx_lock_in & rx_port_enable_in);
          3'h2, 3'h3: return &(rx_pass_in | ~rx_port_enable_in);
          3'h4: return frame_sync_pulse_in;
          default: return 1'h0;
        endcase
      3'h6:
        case (l)
          3'h0: return &(rx_pass_in | ~tx_port_select_in);
          3'h1: return |(rx_pass_in & tx_port_select_in);
          3'h2: return tx_frame_active_in;
          3'h3: return tx_line_active_in;
          3'h4: return tx_synced_in;
          3'h5: return tx_irq_in;
          default: return 1'h0;
        endcase
      default: return 1'h0;
    endcase
  endfunction : exp_pin

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic run_reset();
    logic [31:0] d;
    logic [1:0]  r;
    axr(POM_CTRL_ADDR, d, r);
    chk(d, 32'h0);
    chk({pin2_oe_out, pin2_data_out, pin_level}, 32'h0);
  endtask : run_reset

  task automatic run_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axw(POM_CTRL_ADDR, 32'h13, 4'hF, r);
    axw(POM_CTRL_ADDR, 32'h12, 4'hE, r);
    chk(r, POM_RESP_OKAY);
    repeat (2) @(posedge ref_clk_in);
    chk({pin2_oe_out, pin2_data_out}, 32'h3);
    axr(POM_STAT_ADDR, d, r);
    chk(d, 32'h3);
    axw(8'h10, 32'h12, 4'hF, r);
    chk(r, POM_RESP_SLVERR);
    axr(8'h10, d, r);
    chk({30'h0, r}, {30'h0, POM_RESP_SLVERR});
    chk(d, 32'h0);
    axr(POM_CTRL_ADDR, d, r);
    chk(d, 32'h13);
    // reserved source with the driver on: pin low, reserved flag up
    axw(POM_CTRL_ADDR, 32'h15, 4'hF, r);
    repeat (2) @(posedge ref_clk_in);
    axr(POM_STAT_ADDR, d, r);
    chk(d, 32'h6);
    axw(POM_CTRL_ADDR, 32'h12, 4'hF, r);
    repeat (2) @(posedge ref_clk_in);
    chk({pin2_oe_out, pin2_data_out, pin_level}, 32'h0);
  endtask : run_bus

  task automatic run_mux();
    logic [1:0] r;
    logic       e;
    for (int c = 0; c < 8; c++)
      for (int l = 0; l < 8; l++)
        for (int i = 0; i < 2; i++) begin
          set_in(i[0]);
          axw(POM_CTRL_ADDR, {24'h0, l[2:0], c[2:0], i[0], 1'h1}, 4'hF, r);
          repeat (2) @(posedge ref_clk_in);
          e = exp_pin(c[2:0], l[2:0], i[0]);
          chk({pin2_oe_out, pin2_data_out}, {1'h1, e});
          chk(pin_level, e);
        end
  endtask : run_mux

  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    run_reset();
    run_bus();
    run_mux();
    give_verdict();
  end

  // whole run needs about 700 cycles; this allows more than ten times that
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : pom_pin2_output_mux_tb_top
